// ===== rtl/irdv_enhance.v
// dv receive enhancement control: set/clear register and payload filter
`timescale 1ns/10ps
`include "irdv_map.vh"

// How it works
// - ones at A80h set bits, ones at A84h clear; both read value
// - reserved bits 31-14, 11-10, 7-6, 3-2 read zero, never written
// - header drop bit discards first two payload quadlets of each packet
// - header drop works only while keep-packet-header is zero
// - frame sync waits for dv frame start in buffer-fill, branch 01b
// - frame start out of place makes context jump to misalign target
// - frame sync needs header drop set and keep-packet-header zero
// - keep-packet-header comes from each context's own control register
// - frame start is 1Fh then x7h, first bytes of third quadlet
module irdv_enhance (
   input  wire                    i_mclk,
   input  wire                    i_rstn,
   // register port
   input  wire [`IRDV_ADDR_W-1:0] i_reg_addr,
   input  wire                    i_reg_wr,
   input  wire [31:0]             i_reg_wdata,
   input  wire                    i_reg_rd,
   output wire [31:0]             o_reg_rdata,
   // context control state from the base context logic
   input  wire [3:0]              i_ctx_keep_packet_header,
   input  wire [3:0]              i_ctx_active,
   input  wire [3:0]              i_ctx_run,
   input  wire [3:0]              i_ctx_buffer_fill,
   input  wire [7:0]              i_ctx_branch_ctl,
   input  wire [3:0]              i_ctx_frame_expect,
   // received payload stream
   input  wire                    i_pkt_valid,
   output wire                    o_pkt_ready,
   input  wire [31:0]             i_pkt_data,
   input  wire [1:0]              i_pkt_ctx,
   input  wire                    i_pkt_eop,
   // stored payload stream
   output wire                    o_st_valid,
   input  wire                    i_st_ready,
   output wire [31:0]             o_st_data,
   output wire [1:0]              o_st_ctx,
   output wire                    o_st_eop,
   // context status
   output wire [3:0]              o_header_drop_on,
   output wire [3:0]              o_frame_sync_on,
   output wire [3:0]              o_frame_sync_waiting,
   output wire [3:0]              o_frame_misalign_target,
   output wire [3:0]              o_write_while_busy
);

   ////////////////////////////////////////////////////////////////////////
   // declarations
   ////////////////////////////////////////////////////////////////////////
   reg  [31:0]             enh_r;
   reg  [31:0]             enh_nxt;
   reg  [31:0]             rdata_r;
   reg  [3:0]              waiting_r;
   reg  [3:0]              jump_r;
   reg  [3:0]              busy_wr_r;
   reg  [1:0]              qidx_r;
   reg  [1:0]              qidx_nxt;
   reg                     pass_r;
   reg                     pass_nxt;
   reg                     store;
   reg                     tag_take;
   reg                     jump_take;
   wire [3:0]              drop_eff;
   wire [3:0]              sync_eff;
   wire                    hit_set;
   wire                    hit_clr;
   wire [31:0]             wr_bits;
   wire                    take;
   wire                    tag_hit;
   wire                    sel_drop;
   wire                    sel_sync;
   wire                    sel_wait;
   wire                    sel_expect;
   wire                    fifo_in_ready;
   wire [`IRDV_FIFO_W-1:0] fifo_in_data;
   wire [`IRDV_FIFO_W-1:0] fifo_out_data;

   ////////////////////////////////////////////////////////////////////////
   // enhancement register, set and clear aliases
   ////////////////////////////////////////////////////////////////////////
   assign hit_set = (i_reg_addr == `IRDV_OFS_SET);
   assign hit_clr = (i_reg_addr == `IRDV_OFS_CLR);
   // reserved bits never reach the register
   assign wr_bits = i_reg_wdata & `IRDV_WR_MASK;

   always @* begin
      enh_nxt = enh_r;
      if (i_reg_wr && hit_set) begin
         // or-in keeps zero bits as they were
         enh_nxt = enh_r | wr_bits;
      end else if (i_reg_wr && hit_clr) begin
         enh_nxt = enh_r & ~wr_bits;
      end
   end

   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         enh_r   <= `IRDV_RESET_VAL;
         rdata_r <= 32'h00000000;
      end else begin
         enh_r <= enh_nxt;
         if (i_reg_rd) begin
            // both aliases read the live value, other offsets zero
            if (hit_set || hit_clr) begin
               rdata_r <= enh_r & `IRDV_WR_MASK;
            end else begin
               rdata_r <= 32'h00000000;
            end
         end
      end
   end

   assign o_reg_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // per-context enables and frame sync state
   ////////////////////////////////////////////////////////////////////////
   genvar c;
   generate
      for (c = 0; c < `IRDV_NUM_CTX; c = c + 1) begin : g_ctx
         wire drop_bit;
         wire sync_bit;
         wire bits_changed;

         assign drop_bit = enh_r[`IRDV_CTX_STRIDE*c + `IRDV_DROP_OFS];
         assign sync_bit = enh_r[`IRDV_CTX_STRIDE*c + `IRDV_SYNC_OFS];
         // keep-packet-header is this context's own bit 30
         assign drop_eff[c] = drop_bit
                            & ~i_ctx_keep_packet_header[c];
         assign sync_eff[c] = sync_bit & drop_eff[c]
                            & i_ctx_buffer_fill[c]
                            & (i_ctx_branch_ctl[2*c+1:2*c]
                               == `IRDV_BRANCH_SYNC);
         assign bits_changed =
            (enh_nxt[`IRDV_CTX_STRIDE*c+1:`IRDV_CTX_STRIDE*c]
             != enh_r[`IRDV_CTX_STRIDE*c+1:`IRDV_CTX_STRIDE*c]);

         always @(posedge i_mclk) begin
            if (!i_rstn) begin
               waiting_r[c] <= 1'b1;
               jump_r[c]    <= 1'b0;
               busy_wr_r[c] <= 1'b0;
            end else begin
               // a stopped context re-arms, so each run starts on a frame
               if (!i_ctx_run[c]) begin
                  waiting_r[c] <= 1'b1;
               end else if (tag_take && (i_pkt_ctx == c)) begin
                  waiting_r[c] <= 1'b0;
               end
               jump_r[c] <= jump_take && (i_pkt_ctx == c);
               // sticky flag, cleared only by reset; software misuse marker
               if (bits_changed && (i_ctx_active[c] || i_ctx_run[c])) begin
                  busy_wr_r[c] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   assign o_header_drop_on        = drop_eff;
   assign o_frame_sync_on         = sync_eff;
   assign o_frame_sync_waiting    = waiting_r & sync_eff;
   assign o_frame_misalign_target = jump_r;
   assign o_write_while_busy      = busy_wr_r;

   ////////////////////////////////////////////////////////////////////////
   // payload filter
   ////////////////////////////////////////////////////////////////////////
   assign take       = i_pkt_valid & fifo_in_ready;
   assign o_pkt_ready = fifo_in_ready;
   assign sel_drop   = drop_eff[i_pkt_ctx];
   assign sel_sync   = sync_eff[i_pkt_ctx];
   assign sel_wait   = waiting_r[i_pkt_ctx];
   assign sel_expect = i_ctx_frame_expect[i_pkt_ctx];
   assign tag_hit    = (qidx_r == `IRDV_Q_TAG)
                     && (i_pkt_data[31:24] == `IRDV_TAG_BYTE0)
                     && (i_pkt_data[19:16] == `IRDV_TAG_NIB1);

   always @* begin
      store     = 1'b1;
      tag_take  = 1'b0;
      jump_take = 1'b0;
      pass_nxt  = pass_r;
      qidx_nxt  = qidx_r;
      if (take) begin
         if (i_pkt_eop) begin
            qidx_nxt = 2'h0;
            pass_nxt = 1'b1;
         end else if (qidx_r != `IRDV_Q_BODY) begin
            qidx_nxt = qidx_r + 2'h1;
         end
         if (sel_drop && (qidx_r <= `IRDV_Q_HDR_LAST)) begin
            store = 1'b0;
         end else if (sel_sync && (qidx_r == `IRDV_Q_TAG)) begin
            if (tag_hit) begin
               tag_take  = 1'b1;
               // a tag where no frame is due goes to the alternate list
               jump_take = ~sel_wait & ~sel_expect;
               store     = 1'b1;
            end else begin
               store = ~sel_wait;
            end
            if (!i_pkt_eop) begin
               pass_nxt = store;
            end
         end else if (sel_sync) begin
            // short packets while waiting never get past the tag slot
            store = pass_r & ~sel_wait | pass_r & (qidx_r == `IRDV_Q_BODY);
         end
      end
   end

   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         qidx_r <= 2'h0;
         pass_r <= 1'b1;
      end else begin
         qidx_r <= qidx_nxt;
         pass_r <= pass_nxt;
      end
   end

   // limitation: a dropped end quadlet leaves the stored packet unmarked
   assign fifo_in_data = {i_pkt_eop, i_pkt_ctx, i_pkt_data};

   ////////////////////////////////////////////////////////////////////////
   // stored data buffer
   ////////////////////////////////////////////////////////////////////////
   irdv_fifo #(
      .W     (`IRDV_FIFO_W),
      .DEPTH (`IRDV_FIFO_DEPTH),
      .AW    (`IRDV_FIFO_AW)
   ) u_fifo (
      .i_mclk      (i_mclk),
      .i_rstn      (i_rstn),
      .i_in_valid  (take & store),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (fifo_in_data),
      .o_out_valid (o_st_valid),
      .i_out_ready (i_st_ready),
      .o_out_data  (fifo_out_data)
   );

   assign o_st_data = fifo_out_data[31:0];
   assign o_st_ctx  = fifo_out_data[33:32];
   assign o_st_eop  = fifo_out_data[34];

endmodule // irdv_enhance

// ===== shared/irdv_map.vh
// register map, field layout and pattern constants of the dv receive block
`ifndef IRDV_MAP_VH
`define IRDV_MAP_VH

// register offsets (byte addresses)
`define IRDV_ADDR_W           12
`define IRDV_OFS_SET          12'hA80
`define IRDV_OFS_CLR          12'hA84

// reset value and writable bit mask (bits 13,12,9,8,5,4,1,0)
`define IRDV_RESET_VAL        32'h00000000
`define IRDV_WR_MASK          32'h00003333

// per-context field layout
`define IRDV_NUM_CTX          4
`define IRDV_CTX_STRIDE       4
`define IRDV_DROP_OFS         0
`define IRDV_SYNC_OFS         1

// descriptor branch control value that enables frame sync
`define IRDV_BRANCH_SYNC      2'h1

// dv frame start tag: first byte and low nibble of second byte
`define IRDV_TAG_BYTE0        8'h1F
`define IRDV_TAG_NIB1         4'h7

// payload quadlet indices
`define IRDV_Q_HDR_LAST       2'h1
`define IRDV_Q_TAG            2'h2
`define IRDV_Q_BODY           2'h3

// fifo geometry
`define IRDV_FIFO_DEPTH       16
`define IRDV_FIFO_AW          4
`define IRDV_FIFO_W           35

`endif

// ===== rtl/irdv_fifo.v
// synchronous valid/ready fifo for the stored payload stream
`timescale 1ns/10ps
module irdv_fifo #(
   parameter W     = 35,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire         i_mclk,
   input  wire         i_rstn,
   input  wire         i_in_valid,
   output wire         o_in_ready,
   input  wire [W-1:0] i_in_data,
   output wire         o_out_valid,
   input  wire         i_out_ready,
   output wire [W-1:0] o_out_data
);

   reg [W-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0]   count_r;
   wire         push;
   wire         pop;

   assign o_in_ready  = (count_r != DEPTH[AW:0]);
   assign o_out_valid = (count_r != {(AW+1){1'b0}});
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;
   assign o_out_data  = mem[rd_ptr_r];

   always @(posedge i_mclk) begin
      if (push) begin
         mem[wr_ptr_r] <= i_in_data;
      end
   end

   always @(posedge i_mclk) begin
      if (!i_rstn) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push & ~pop) begin
            count_r <= count_r + {{AW{1'b0}}, 1'b1};
         end else if (pop & ~push) begin
            count_r <= count_r - {{AW{1'b0}}, 1'b1};
         end
      end
   end

endmodule // irdv_fifo

// ===== sim/irdv_monitor.sv
// checker for the dv receive enhancement block
`timescale 1ns/10ps
`include "irdv_map.vh"
module irdv_monitor (
   input wire                    i_mclk,
   input wire                    i_rstn,
   input wire [`IRDV_ADDR_W-1:0] i_reg_addr,
   input wire                    i_reg_wr,
   input wire [31:0]             i_reg_wdata,
   input wire                    i_reg_rd,
   input wire [31:0]             o_reg_rdata,
   input wire [3:0]              i_ctx_keep_packet_header,
   input wire [3:0]              i_ctx_buffer_fill,
   input wire [3:0]              o_header_drop_on,
   input wire [3:0]              o_frame_sync_on,
   input wire                    o_st_valid,
   input wire                    i_st_ready,
   input wire [31:0]             o_st_data
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   ////////////////////////////////////////////////////////////////////////
   property p_rsvd;
      (o_reg_rdata & 32'hFFFFCCCC) == 32'h00000000;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bit reads nonzero");
   property p_unmap;
      i_reg_rd && i_reg_addr != 12'hA80 && i_reg_addr != 12'hA84
         |=> o_reg_rdata == 32'h00000000;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read nonzero");
   // write, one idle cycle, then read back through the other alias
   property p_set;
      i_reg_wr && i_reg_addr == 12'hA80 ##2 i_reg_rd && !i_reg_wr
         && i_reg_addr == 12'hA84 |=> ((o_reg_rdata ^ $past(i_reg_wdata, 3))
         & $past(i_reg_wdata, 3) & 32'h00003333) == 32'h00000000;
   endproperty
   a_set: assert property (p_set)
      else $error("set alias did not set bits");
   property p_clr;
      i_reg_wr && i_reg_addr == 12'hA84 ##2 i_reg_rd && !i_reg_wr
         && i_reg_addr == 12'hA80
         |=> (o_reg_rdata & $past(i_reg_wdata, 3)) == 32'h00000000;
   endproperty
   a_clr: assert property (p_clr)
      else $error("clear alias did not clear bits");
   property p_keep;
      (o_header_drop_on & i_ctx_keep_packet_header) == 4'h0;
   endproperty
   a_keep: assert property (p_keep)
      else $error("header drop active with header kept");
   property p_sync;
      (o_frame_sync_on & ~o_header_drop_on) == 4'h0;
   endproperty
   a_sync: assert property (p_sync)
      else $error("frame sync active without header drop");
   property p_fill;
      (o_frame_sync_on & ~i_ctx_buffer_fill) == 4'h0;
   endproperty
   a_fill: assert property (p_fill)
      else $error("frame sync active outside buffer fill");
   property p_hold;
      o_st_valid && !i_st_ready |=> o_st_valid && $stable(o_st_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("stored quadlet changed while stalled");
endmodule // irdv_monitor
bind irdv_enhance irdv_monitor i_mon (.i_mclk, .i_rstn, .i_reg_addr,
   .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata,
   .i_ctx_keep_packet_header, .i_ctx_buffer_fill, .o_header_drop_on,
   .o_frame_sync_on, .o_st_valid, .i_st_ready, .o_st_data);

// ===== sim/irdv_sink.sv
// partner model: receive dma side that takes the stored stream
`timescale 1ns/10ps
module irdv_sink (
   input  wire        i_mclk,
   input  wire        i_stall,
   input  wire        i_valid,
   input  wire [31:0] i_data,
   output reg         o_ready
);
   logic [31:0] got[$];
   // registered ready, so a stall lands one cycle late like a real master
   always @(posedge i_mclk) begin
      o_ready <= !i_stall;
      if (i_valid && o_ready)
         got.push_back(i_data);
   end
endmodule // irdv_sink

// ===== sim/tb_top.sv
// self-checking bench for the dv receive enhancement block
`timescale 1ns/10ps
`include "irdv_map.vh"
module tb_top;
   reg         i_mclk = 1'b0;
   reg         i_rstn = 1'b0;
   reg  [11:0] ra = 12'h000;
   reg  [31:0] wd = 32'h00000000, pd = 32'h00000000;
   reg         rw = 1'b0, rr = 1'b0, pv = 1'b0, pe = 1'b0, stall = 1'b0;
   reg  [3:0]  keep = 4'h0, act = 4'h0, run = 4'h0, fill = 4'h0, exf = 4'h0;
   reg  [7:0]  br = 8'h00;
   reg  [1:0]  pc = 2'h0;
   wire [31:0] rdat, sd;
   wire        prdy, sv, sr;
   wire [3:0]  dron, syon, mis, busy;
   wire [3:0]  wt;
   wire [1:0]  sctx;
   wire        seop;
   integer     error_cnt = 0, n_checks = 0, mis_cnt = 0, i, eop_cnt = 0;
   reg  [31:0] v;
   always #4 i_mclk = ~i_mclk;
   always @(posedge i_mclk) if (mis[0] === 1'b1) mis_cnt <= mis_cnt + 1;
   always @(posedge i_mclk) if (sv && sr && seop === 1'b1)
      eop_cnt <= eop_cnt + 1;
   irdv_enhance i_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_reg_addr(ra),
      .i_reg_wr(rw), .i_reg_wdata(wd), .i_reg_rd(rr), .o_reg_rdata(rdat),
      .i_ctx_keep_packet_header(keep), .i_ctx_active(act), .i_ctx_run(run),
      .i_ctx_buffer_fill(fill), .i_ctx_branch_ctl(br),
      .i_ctx_frame_expect(exf), .i_pkt_valid(pv), .o_pkt_ready(prdy),
      .i_pkt_data(pd), .i_pkt_ctx(pc), .i_pkt_eop(pe), .o_st_valid(sv),
      .i_st_ready(sr), .o_st_data(sd), .o_st_ctx(sctx), .o_st_eop(seop),
      .o_header_drop_on(dron), .o_frame_sync_on(syon),
      .o_frame_sync_waiting(wt), .o_frame_misalign_target(mis),
      .o_write_while_busy(busy));
   irdv_sink i_sink (.i_mclk(i_mclk), .i_stall(stall), .i_valid(sv),
      .i_data(sd), .o_ready(sr));
   ////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input [31:0] s, input [31:0] e);
      n_checks = n_checks + 1;
      if (s !== e) begin
         error_cnt = error_cnt + 1;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task wr(input [11:0] a, input [31:0] d);
      @(posedge i_mclk);
      ra <= a;
      wd <= d;
      rw <= 1'b1;
      @(posedge i_mclk);
      rw <= 1'b0;
   endtask
   task rd(input [11:0] a, output [31:0] d);
      @(posedge i_mclk);
      ra <= a;
      rr <= 1'b1;
      @(posedge i_mclk);
      rr <= 1'b0;
      #1 d = rdat;
   endtask
   task push(input [1:0] c, input [31:0] d, input e);
      integer n;
      @(posedge i_mclk);
      pv <= 1'b1;
      pc <= c;
      pd <= d;
      pe <= e;
      #1;
      for (n = 0; n < 100 && prdy !== 1'b1; n = n + 1) @(posedge i_mclk) #1;
      if (n == 100) begin
         chk("push wait", 32'h0, 32'h1);
         finish_test;
      end
      @(posedge i_mclk);
      pv <= 1'b0;
   endtask
   // four quadlet packet: two header quadlets, tag slot, eop body
   task pkt(input [1:0] c, input [31:0] tq, input integer n);
      integer k;
      push(c, 32'hA0000000, 1'b0);
      push(c, 32'hA1000001, 1'b0);
      push(c, tq, 1'b0);
      push(c, 32'hB0000003, 1'b1);
      repeat (2) @(posedge i_mclk);
      #1;
      for (k = 0; k < 100 && sv !== 1'b0; k = k + 1) @(posedge i_mclk) #1;
      if (k == 100) begin
         chk("drain wait", 32'h0, 32'h1);
         finish_test;
      end
      chk("stored count", i_sink.got.size(), n);
      if (n == 2) chk("tag slot", i_sink.got[0], tq);
      i_sink.got.delete();
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_regs;
      rd(12'hA80, v);
      chk("reset value", v, 32'h00000000);
      wr(12'hA80, 32'hFFFFFFFF);
      rd(12'hA84, v);
      chk("set all", v, 32'h00003333);
      wr(12'hA84, 32'h00000011);
      rd(12'hA80, v);
      chk("clear some", v, 32'h00003322);
      wr(12'hA80, 32'h00000000);
      rd(12'hA84, v);
      chk("zero write", v, 32'h00003322);
      wr(12'hA88, 32'hFFFFFFFF);
      rd(12'hA88, v);
      chk("unmapped", v, 32'h00000000);
      wr(12'hA84, 32'hFFFFFFFF);
      rd(12'hA80, v);
      chk("clear all", v, 32'h00000000);
      $display("test regs done");
   endtask
   task t_drop;
      wr(12'hA80, 32'h00000010);
      #1 chk("drop on", dron, 4'h2);
      pkt(2'h1, 32'h12345678, 2);
      @(posedge i_mclk) keep <= 4'h2;
      #1 chk("drop off", dron, 4'h0);
      pkt(2'h1, 32'h12345678, 4);
      @(posedge i_mclk) keep <= 4'h0;
      wr(12'hA84, 32'h00000010);
      $display("test drop done");
   endtask
   task t_sync;
      wr(12'hA80, 32'h00000003);
      @(posedge i_mclk);
      fill <= 4'h1;
      br <= 8'h01;
      exf <= 4'h1;
      run <= 4'h1;
      act <= 4'h1;
      #1 chk("sync on", syon, 4'h1);
      pkt(2'h0, 32'h1F180000, 0);
      chk("still waiting", wt, 4'h1);
      pkt(2'h0, 32'h1F970000, 2);
      chk("frame found", wt, 4'h0);
      chk("no jump", mis_cnt, 0);
      @(posedge i_mclk) exf <= 4'h0;
      pkt(2'h0, 32'h1F070000, 2);
      chk("one jump", mis_cnt, 1);
      @(posedge i_mclk) run <= 4'h0;
      act <= 4'h0;
      wr(12'hA84, 32'h00000001);
      #1 chk("sync needs drop", syon, 4'h0);
      wr(12'hA84, 32'h00000002);
      $display("test sync done");
   endtask
   task t_busy;
      @(posedge i_mclk) run <= 4'h4;
      wr(12'hA80, 32'h00000100);
      #1 chk("busy write", busy, 4'h4);
      @(posedge i_mclk) run <= 4'h0;
      wr(12'hA84, 32'h00000100);
      $display("test busy done");
   endtask
   task t_fifo;
      integer e0;
      e0 = eop_cnt;
      @(posedge i_mclk) stall <= 1'b1;
      for (i = 0; i < 16; i = i + 1) push(2'h2, i, i == 15);
      #1 chk("fifo full", prdy, 1'b0);
      chk("head ctx", sctx, 2'h2);
      chk("head data", sd, 32'h00000000);
      chk("head eop", seop, 1'b0);
      @(posedge i_mclk) stall <= 1'b0;
      #1;
      for (i = 0; i < 100 && sv !== 1'b0; i = i + 1) @(posedge i_mclk) #1;
      if (i == 100) begin
         chk("drain wait", 32'h0, 32'h1);
         finish_test;
      end
      chk("drained", i_sink.got.size(), 16);
      chk("last out", i_sink.got[15], 32'h0000000F);
      chk("one eop", eop_cnt - e0, 32'h00000001);
      $display("test fifo done");
   endtask
   initial begin
      repeat (4) @(posedge i_mclk);
      i_rstn <= 1'b1;
      t_regs;
      t_drop;
      t_sync;
      t_busy;
      t_fifo;
      finish_test;
   end
endmodule // tb_top
